//--- core/can_gen_defs.svh
`ifndef CAN_GEN_DEFS_SVH
`define CAN_GEN_DEFS_SVH
`define ADDR_GEN_CONTROL 3'h0
`define ADDR_GEN_STATUS 3'h1
`define ADDR_GEN_IRQ_FLAGS 3'h2
`define ADDR_GEN_IRQ_ENABLE 3'h3
`define ADDR_OBJ_EN_LOW 3'h4
`define ADDR_OBJ_EN_HIGH 3'h5
`define CTL_ABORT 7
`define CTL_OVERLOAD 6
`define CTL_TTC 5
`define CTL_SYNC 4
`define CTL_ONLY_MODE_A 3
`define CTL_TEST 2
`define CTL_ENABLE 1
`define CTL_SOFT_RESET_REQUEST 0
`define STA_OVERLOAD 6
`define STA_TRANSMITTER_BUSY_FLAG 4
`define STA_RECEIVER_BUSY_FLAG 3
`define STA_ENABLE_STATUS_FLAG 2
`define STA_BUS_OFF_STATE 1
`define STA_ERROR_PASSIVE_STATE 0
`define IRQ_ANY 7
`define IRQ_BUS_OFF_STATE 6
`define IRQ_TIMER_OVERRUN_FLAG 5
`define IRQ_BUF 4
`define IRQ_STUFF 3
`define IRQ_CRC 2
`define IRQ_FORM 1
`define IRQ_ACK 0
`define IE_GLOBAL 7
`define IE_BUS_OFF_STATE 6
`define IE_RX 5
`define IE_TX 4
`define IE_ERR 3
`define IE_BUF 2
`define IE_GERR 1
`define IE_OVRT 0
`define CTL_RESET 8'h00
`define IE_RESET 8'h00
`define RECESSIVE_BITS 4'hb
`define STATUS_RESERVED_MASK 8'h5f
`endif

//--- core/can_gen_pkg.sv
package can_gen_pkg;
    typedef struct packed {
        logic tx_busy;
        logic rx_busy;
        logic overload_sending;
        logic tx_in_progress;
        logic bus_off;
        logic err_passive;
        logic sample_tick;
        logic sample_recessive;
    } core_status_t;
    typedef struct packed {
        logic stuff_err;
        logic crc_err;
        logic form_err;
        logic ack_err;
        logic timer_wrap;
        logic buffer_done;
        logic buffer_rewritten;
        logic rx_pending;
        logic tx_pending;
        logic err_pending;
    } core_events_t;
    typedef struct packed {
        logic abort_request;
        logic overload_request;
        logic time_triggered_mode;
        logic capture_at_eof;
        logic only_mode_a;
        logic test_mode;
        logic channel_enabled;
        logic tx_recessive_hold;
        logic controller_reset;
    } core_control_t;
    typedef enum logic [1:0] {
        CH_STANDBY = 2'b00,
        CH_WAIT_IDLE = 2'b01,
        CH_ENABLED = 2'b10,
        CH_DRAIN = 2'b11
    } chan_state_t;
endpackage

//--- core/can_gen_regs.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "can_gen_defs.svh"
module can_gen_regs
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Protocol core
    input wire can_gen_pkg::core_status_t core_status,
    input wire can_gen_pkg::core_events_t core_events,
    input wire logic [14:0] object_enable_set,
    input wire logic [14:0] object_done_clear,
    input wire logic overrun_irq_ack,
    output can_gen_pkg::core_control_t core_control,
    output logic [14:0] object_in_use_bits,
    output logic can_irq,
    output logic overrun_irq
);
    import can_gen_pkg::*;

    logic [7:0] general_control;
    logic [7:0] gen_irq_flags;
    logic [7:0] general_interrupt_enable;
    chan_state_t chan_state;
    chan_state_t next_chan_state;
    logic [3:0] recessive_count;
    logic enable_status_flag;
    logic soft_reset_request;
    logic prev_bus_off;
    logic ctl_rst;

    // Controller reset, hardware ORed with software
    assign soft_reset_request = general_control[`CTL_SOFT_RESET_REQUEST];
    assign ctl_rst = sys_rst | soft_reset_request;

    wire wr_ctl = reg_write && reg_addr == `ADDR_GEN_CONTROL;
    wire wr_irq = reg_write && reg_addr == `ADDR_GEN_IRQ_FLAGS;
    wire wr_ie = reg_write && reg_addr == `ADDR_GEN_IRQ_ENABLE;
    wire enable_command = general_control[`CTL_ENABLE];
    wire abort_request = general_control[`CTL_ABORT];

    // Enable / standby sequencing
    always_comb
    begin
        next_chan_state = chan_state;
        unique case (chan_state)
            CH_STANDBY:
                if (enable_command)
                    next_chan_state = CH_WAIT_IDLE;
            CH_WAIT_IDLE:
                if (!enable_command)
                    next_chan_state = CH_STANDBY;
                else if (core_status.sample_tick && core_status.sample_recessive
                    && recessive_count == `RECESSIVE_BITS - 4'h1)
                    next_chan_state = CH_ENABLED;
            CH_ENABLED:
                if (!enable_command)
                    next_chan_state = CH_DRAIN;
            CH_DRAIN:
                if (!core_status.tx_in_progress)
                    next_chan_state = CH_STANDBY;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (ctl_rst)
        begin
            chan_state <= CH_STANDBY;
            recessive_count <= 4'h0;
        end
        else
        begin
            chan_state <= next_chan_state;
            if (chan_state != CH_WAIT_IDLE)
                recessive_count <= 4'h0;
            else if (core_status.sample_tick)
                recessive_count <= core_status.sample_recessive ?
                    recessive_count + 4'h1 : 4'h0;
        end
    end

    assign enable_status_flag = chan_state == CH_ENABLED
        || chan_state == CH_DRAIN;

    // Control register; soft reset bit clears on the following edge
    always_ff @(posedge sys_clk)
    begin
        if (ctl_rst)
            general_control <= `CTL_RESET;
        else if (wr_ctl)
            general_control <= reg_wdata;
    end

    // Object-in-use bits
    wire standby_entry = chan_state != CH_STANDBY
        && next_chan_state == CH_STANDBY;
    always_ff @(posedge sys_clk)
    begin
        if (ctl_rst)
            object_in_use_bits <= 15'h0000;
        else if (abort_request || standby_entry)
            object_in_use_bits <= 15'h0000;
        else
            object_in_use_bits <= (object_in_use_bits & ~object_done_clear)
                | object_enable_set;
    end

    // Interrupt flags: set wins over write-one clear
    wire [7:0] flag_clear = wr_irq ? reg_wdata : 8'h00;
    wire entered_bus_off_state = core_status.bus_off && !prev_bus_off
        && core_status.err_passive;
    wire buf_clear_ok = core_events.buffer_rewritten;
    wire [7:0] flag_set = {1'b0, entered_bus_off_state, core_events.timer_wrap,
        core_events.buffer_done, core_events.stuff_err, core_events.crc_err,
        core_events.form_err, core_events.ack_err};
    wire [7:0] clear_mask = {1'b0, flag_clear[`IRQ_BUS_OFF_STATE],
        flag_clear[`IRQ_TIMER_OVERRUN_FLAG] | overrun_irq_ack,
        flag_clear[`IRQ_BUF] & buf_clear_ok, flag_clear[3:0]};

    always_ff @(posedge sys_clk)
    begin
        if (ctl_rst)
        begin
            gen_irq_flags <= 8'h00;
            prev_bus_off <= 1'b0;
        end
        else
        begin
            gen_irq_flags <= ((gen_irq_flags & ~clear_mask) | flag_set)
                & 8'h7f;
            prev_bus_off <= core_status.bus_off;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (ctl_rst)
            general_interrupt_enable <= `IE_RESET;
        else if (wr_ie)
            general_interrupt_enable <= reg_wdata;
    end

    // Source gating
    wire [7:0] ie = general_interrupt_enable;
    wire gerr_any = |gen_irq_flags[3:0];
    wire any_source = (ie[`IE_BUS_OFF_STATE] & gen_irq_flags[`IRQ_BUS_OFF_STATE])
        | (ie[`IE_RX] & core_events.rx_pending)
        | (ie[`IE_TX] & core_events.tx_pending)
        | (ie[`IE_ERR] & core_events.err_pending)
        | (ie[`IE_BUF] & gen_irq_flags[`IRQ_BUF])
        | (ie[`IE_GERR] & gerr_any);
    wire any_interrupt_flag = any_source;
    assign can_irq = ie[`IE_GLOBAL] & any_interrupt_flag;
    assign overrun_irq = ie[`IE_OVRT] & gen_irq_flags[`IRQ_TIMER_OVERRUN_FLAG];

    // Status image; reserved bits zero
    wire [7:0] status_image = {1'b0, core_status.overload_sending, 1'b0,
        core_status.tx_busy, core_status.rx_busy, enable_status_flag,
        core_status.bus_off, core_status.err_passive}
        & `STATUS_RESERVED_MASK;

    // Protocol core controls
    assign core_control.abort_request = abort_request;
    assign core_control.overload_request = general_control[`CTL_OVERLOAD];
    assign core_control.time_triggered_mode = general_control[`CTL_TTC];
    assign core_control.capture_at_eof = general_control[`CTL_TTC]
        & general_control[`CTL_SYNC];
    assign core_control.only_mode_a = general_control[`CTL_ONLY_MODE_A];
    assign core_control.test_mode = general_control[`CTL_TEST];
    // Channel keeps running while draining so a frame in flight completes
    assign core_control.channel_enabled = chan_state == CH_ENABLED
        || chan_state == CH_DRAIN;
    assign core_control.tx_recessive_hold = chan_state == CH_STANDBY
        || chan_state == CH_WAIT_IDLE;
    assign core_control.controller_reset = ctl_rst;

    // Read mux
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr)
            `ADDR_GEN_CONTROL: rd_mux = general_control;
            `ADDR_GEN_STATUS: rd_mux = status_image;
            `ADDR_GEN_IRQ_FLAGS: rd_mux = {any_interrupt_flag,
                gen_irq_flags[6:0]};
            `ADDR_GEN_IRQ_ENABLE: rd_mux = general_interrupt_enable;
            `ADDR_OBJ_EN_LOW: rd_mux = object_in_use_bits[7:0];
            `ADDR_OBJ_EN_HIGH: rd_mux = {1'b0, object_in_use_bits[14:8]};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= rd_mux;
        else
            reg_rdata <= 8'h00;
    end
endmodule

//--- dv/can_bus_node.sv
`timescale 1ns/1ns
module can_bus_node
(
    // Clock
    input wire logic sys_clk,
    // Bus state asked by the bench
    input wire logic bus_idle,
    input wire can_gen_pkg::core_status_t want,
    // Seen by the controller
    output can_gen_pkg::core_status_t st
);
    import can_gen_pkg::*;
    logic [2:0] ph = 3'h0;
    always_ff @(posedge sys_clk)
        ph <= ph + 3'h1;
    // Busy bus alternates level per bit, idle bus stays recessive
    always_comb
    begin
        st = want;
        st.sample_tick = ph[1:0] == 2'h0;
        st.sample_recessive = bus_idle | ph[2];
    end
endmodule

//--- dv/can_gen_regs_properties.sv
`timescale 1ns/1ns
module can_gen_regs_props
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Protocol core
    input wire can_gen_pkg::core_status_t core_status,
    input wire logic [14:0] object_enable_set,
    input wire can_gen_pkg::core_control_t core_control,
    input wire logic [14:0] object_in_use_bits
);
    import can_gen_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire ctl_wr = reg_write && reg_addr == 3'h0;
    wire rec_tick = core_status.sample_tick && core_status.sample_recessive;
    wire [6:0] obj_top = object_in_use_bits[14:8];
    soft_reset_request_pulse_a: assert property (ctl_wr && reg_wdata[0]
        |=> core_control.controller_reset ##1 !core_control.controller_reset)
        else $error("soft reset pulse");
    ctl_store_a: assert property (ctl_wr && !reg_wdata[0]
        && !core_control.controller_reset
        |=> core_control.abort_request == $past(reg_wdata[7])
        && core_control.overload_request == $past(reg_wdata[6])
        && core_control.only_mode_a == $past(reg_wdata[3]))
        else $error("control store");
    sync_ignored_a: assert property (!core_control.time_triggered_mode
        |-> !core_control.capture_at_eof) else $error("sync select");
    abort_clear_a: assert property (core_control.abort_request
        && object_enable_set == 15'h0 |=> object_in_use_bits == 15'h0)
        else $error("abort clear");
    enable_tick_a: assert property ($rose(core_control.channel_enabled)
        |-> $past(rec_tick)) else $error("enable timing");
    drain_hold_a: assert property (core_control.channel_enabled
        && core_status.tx_in_progress && !core_control.controller_reset
        |=> core_control.channel_enabled) else $error("drain");
    reserved_read_a: assert property (reg_read && reg_addr[2:1] == 2'h3
        |=> reg_rdata == 8'h00) else $error("reserved read");
    obj_high_a: assert property (reg_read && reg_addr == 3'h5
        |=> reg_rdata == {1'b0, $past(obj_top)}) else $error("object high");
endmodule
bind can_gen_regs can_gen_regs_props can_gen_regs_props_i (.*);

//--- dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    import can_gen_pkg::*;
    logic sys_clk, sys_rst, reg_write, reg_read, ack, rew, idle;
    logic can_irq, overrun_irq;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [14:0] oset, oclr, obj;
    core_status_t want, st;
    core_events_t evp;
    core_control_t ctl;
    int errors, total_checks, i;
    int rec_run = 0;
    can_bus_node can_bus_node_i (.sys_clk(sys_clk), .bus_idle(idle),
        .want(want), .st(st));
    can_gen_regs can_gen_regs_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .core_status(st),
        .core_events(evp | {6'h0, rew, 3'h0}), .object_enable_set(oset),
        .object_done_clear(oclr), .overrun_irq_ack(ack),
        .core_control(ctl), .object_in_use_bits(obj), .can_irq(can_irq),
        .overrun_irq(overrun_irq));
    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Consecutive recessive bits offered to the controller
    always @(posedge sys_clk)
        if (st.sample_tick)
            rec_run <= st.sample_recessive ? rec_run + 1 : 0;
    task cmp(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask
    task pulse(input logic [9:0] e, input logic [14:0] s, c);
        @(posedge sys_clk);
        evp <= e;
        oset <= s;
        oclr <= c;
        @(posedge sys_clk);
        {evp, oset, oclr} <= '0;
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        wrap_up;
    end
    initial
    begin
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_write, reg_read, ack, rew, idle} = '0;
        {want, evp, oset, oclr} = '0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++)
            rd(i[2:0], 8'h00);
        $display("reset values done");
        wr(3'h0, 8'h7c);
        rd(3'h0, 8'h7c);
        cmp({3'h0, ctl.test_mode, ctl.time_triggered_mode, ctl.capture_at_eof,
            ctl.overload_request, ctl.only_mode_a}, 8'h1f);
        wr(3'h1, 8'hff);
        rd(3'h1, 8'h00);
        wr(3'h0, 8'h00);
        pulse(10'h0, 15'h7fff, 15'h0);
        rd(3'h5, 8'h7f);
        pulse(10'h0, 15'h0, 15'h0101);
        rd(3'h4, 8'hfe);
        wr(3'h0, 8'h80);
        rd(3'h5, 8'h00);
        rd(3'h0, 8'h80);
        wr(3'h0, 8'h00);
        $display("control and objects done");
        pulse(10'h3c0, 15'h0, 15'h0);
        wr(3'h2, 8'h00);
        rd(3'h2, 8'h0f);
        wr(3'h3, 8'h82);
        rd(3'h2, 8'h8f);
        cmp({7'h0, can_irq}, 8'h01);
        wr(3'h3, 8'h80);
        rd(3'h2, 8'h0f);
        cmp({7'h0, can_irq}, 8'h00);
        wr(3'h2, 8'h0f);
        rd(3'h2, 8'h00);
        pulse(10'h020, 15'h0, 15'h0);
        wr(3'h3, 8'h83);
        rd(3'h2, 8'h20);
        cmp({7'h0, overrun_irq}, 8'h01);
        ack <= 1'b1;
        @(posedge sys_clk);
        ack <= 1'b0;
        rd(3'h2, 8'h00);
        pulse(10'h010, 15'h0, 15'h0);
        wr(3'h2, 8'h10);
        rd(3'h2, 8'h10);
        rew <= 1'b1;
        wr(3'h2, 8'h10);
        rew <= 1'b0;
        rd(3'h2, 8'h00);
        want <= 8'h04;
        rd(3'h2, 8'h00);
        want <= 8'hfc;
        rd(3'h1, 8'h5b);
        rd(3'h2, 8'h40);
        wr(3'h2, 8'h40);
        want <= 8'h00;
        @(posedge sys_clk);
        want <= 8'h08;
        rd(3'h2, 8'h00);
        $display("interrupts done");
        want <= 8'h00;
        pulse(10'h0, 15'h0003, 15'h0);
        wr(3'h0, 8'h02);
        repeat (60) @(posedge sys_clk);
        rd(3'h1, 8'h00);
        cmp({7'h0, ctl.tx_recessive_hold}, 8'h01);
        idle <= 1'b1;
        for (i = 0; i < 200 && ctl.channel_enabled !== 1'b1; i++)
            @(posedge sys_clk);
        cmp(rec_run[7:0], 8'h0b);
        rd(3'h1, 8'h04);
        cmp({7'h0, ctl.tx_recessive_hold}, 8'h00);
        want <= 8'h10;
        wr(3'h0, 8'h82);
        rd(3'h4, 8'h00);
        wr(3'h0, 8'h00);
        repeat (4) @(posedge sys_clk);
        rd(3'h1, 8'h04);
        cmp({7'h0, ctl.channel_enabled}, 8'h01);
        want <= 8'h00;
        repeat (4) @(posedge sys_clk);
        rd(3'h1, 8'h00);
        cmp({7'h0, ctl.tx_recessive_hold}, 8'h01);
        wr(3'h0, 8'h79);
        repeat (2) @(posedge sys_clk);
        rd(3'h0, 8'h00);
        rd(3'h3, 8'h00);
        $display("enable and soft reset done");
        wrap_up;
    end
endmodule
